// >>> verilog/cplc_pkg.sv
// Purpose: Shared constants and types for the channel power and extra lane control block
// Assumes: APB data 32 bits; registers hold 8 bits in the low byte
// Notes:   Register offsets are word indices; byte address is four times the index
package cplc_pkg;

   // ======================================================================
   // Bus geometry
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 32;
   localparam int          REG_W           = 8;
   localparam int          IDX_LSB         = 2;
   localparam int          IDX_W           = 10;
   localparam logic [1:0]  ALIGN_OK        = 2'h0;

   // ======================================================================
   // Register indices
   localparam logic [9:0]  IDX_CHAN_PD     = 10'h209;
   localparam logic [9:0]  IDX_EXTRA_A     = 10'h20a;
   localparam logic [9:0]  IDX_EXTRA_B     = 10'h20b;
   localparam logic [9:0]  IDX_LINK_CTRL   = 10'h3f0;
   localparam logic [9:0]  IDX_LINK_MODE   = 10'h3f1;
   localparam logic [9:0]  IDX_LINK_TEST   = 10'h3f2;
   localparam logic [9:0]  IDX_STATUS      = 10'h3f3;
   localparam logic [7:0]  REG_RESET       = 8'h00;

   // ======================================================================
   // Field positions
   localparam int          PD_A_BIT        = 0;
   localparam int          PD_B_BIT        = 1;
   localparam int          EXTRA_SER_BIT   = 0;
   localparam int          CTRL_EN_BIT     = 0;
   localparam int          CTRL_BIND_A_BIT = 1;
   localparam int          CTRL_BIND_B_BIT = 2;
   localparam int          CTRL_AB_ON_A    = 3;
   localparam int          TEST_W          = 5;
   localparam int          LANES           = 8;

   // ======================================================================
   // Test pattern codes
   localparam logic [4:0]  TEST_NORMAL     = 5'h00;
   localparam logic [4:0]  TEST_ALT_RAMP   = 5'h05;
   localparam logic [4:0]  TEST_RAMP       = 5'h04;

   // ======================================================================
   // APB phase tracker
   typedef enum logic [1:0]
   {
      CPLC_IDLE   = 2'b01,
      CPLC_ACCESS = 2'b10
   } cplc_phase_t;

endpackage

// >>> verilog/cplc_link_if.sv
// Purpose: Per-link lane control signals between the top and a lane controller
// Assumes: One instance per serial link
// Notes:   ctrl side drives requests, lane side answers combinationally
`timescale 1ns/100ps
interface cplc_link_if;
   logic [7:0] extra;
   logic       link_on;
   logic [7:0] mode_lanes;
   logic [4:0] test_sel;
   logic [7:0] lane_clk;
   logic [7:0] ser_en;
   logic [7:0] ramp_force;

   modport ctrl
   (
      output extra, link_on, mode_lanes, test_sel,
      input  lane_clk, ser_en, ramp_force
   );
   modport lane
   (
      input  extra, link_on, mode_lanes, test_sel,
      output lane_clk, ser_en, ramp_force
   );
endinterface

// >>> verilog/cplc_lane_ctrl.sv
// Purpose: Lane clock, serializer and pattern enables for one link
// Assumes: Lane 0 is always a mode lane when the link carries data
// Notes:   Purely combinational; the top registers the results
`timescale 1ns/100ps
module cplc_lane_ctrl
   import cplc_pkg::*;
(
   cplc_link_if.lane lk
);
   logic [LANES-1:0] req;
   logic             alt_test;

   assign alt_test = (lk.test_sel == TEST_NORMAL) || (lk.test_sel == TEST_ALT_RAMP);

   genvar n;
   generate
      for (n = 0; n < LANES; n++)
      begin : g_lane
         if (n == 0)
         begin : g_base
            assign req[n] = lk.mode_lanes[n];
         end
         else
         begin : g_ext
            assign req[n] = lk.mode_lanes[n] | lk.extra[n];
         end
         assign lk.lane_clk[n]   = lk.link_on & req[n];
         assign lk.ser_en[n]     = lk.lane_clk[n] & (&req[n:0]) & (lk.mode_lanes[n] | lk.extra[EXTRA_SER_BIT]);
         assign lk.ramp_force[n] = lk.lane_clk[n] & ~lk.mode_lanes[n] & alt_test;
      end
   endgenerate
endmodule

// >>> verilog/cplc_chan_pwr.sv
// Purpose: Converter channel, digital channel and link subsystem power decisions
// Assumes: Binding bit set moves a digital channel onto the other converter
// Notes:   Purely combinational; the top registers the results
`timescale 1ns/100ps
module cplc_chan_pwr
(
   input  wire logic       pd_a,
   input  wire logic       pd_b,
   input  wire logic       bind_a,
   input  wire logic       bind_b,
   input  wire logic       link_en,
   input  wire logic       ab_on_a,
   output logic            conv_a_pd,
   output logic            conv_b_pd,
   output logic            dig_a_pd,
   output logic            dig_b_pd,
   output logic            subsys_pd,
   output logic            link_a_on,
   output logic            link_b_on,
   output logic            b_undef
);
   assign conv_b_pd = pd_b;
   assign conv_a_pd = pd_a;
   assign dig_a_pd  = bind_a ? pd_b : pd_a;
   assign dig_b_pd  = bind_b ? pd_a : pd_b;
   assign subsys_pd = pd_a & pd_b;
   assign link_a_on = link_en & ~subsys_pd & (~dig_a_pd | (ab_on_a & ~dig_b_pd));
   assign link_b_on = link_en & ~subsys_pd & ~ab_on_a & ~dig_b_pd;
   assign b_undef   = link_a_on & ab_on_a & dig_b_pd;
endmodule

// >>> verilog/cplc_top.sv
// Purpose: APB register bank for channel power-down and extra lane enables
// Assumes: Single clock mclk at 100 MHz; rstn asynchronous active low
// Notes:   Every transfer takes one setup and one access cycle, no waits
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps

// What this block does
// - Channel B power-down bit powers down converter channel B.
// - Channel A power-down bit powers down converter channel A.
// - Digital channels bound to a powered-down converter are also powered down.
// - Both channels down shuts the whole serial link subsystem.
// - Combined mode on link A keeps running with B samples undefined.
// - Extra-lane bit n (n 1 to 7) enables lane n even if mode does not; bit 0 never enables lane 0.
// - Extra-lane bit turns on that lane's link-layer clocks.
// - Extra-serializer bit picks clocks only or clocks plus serializers.
// - Extra lanes take rate and mode from mode and test selections.
// - Extra-only lanes with test 0 or 5 send octet ramp.
// - Extra lanes never override power-down; link must be running.
// - Serializer n clocked only when lanes 0 to n-1 enabled.
// - Link B extra-lane register mirrors link A layout.
module cplc_top
   import cplc_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rstn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   input  wire logic [3:0]        pstrb,
   input  wire logic [7:0]        mode_lanes_a,
   input  wire logic [7:0]        mode_lanes_b,
   output logic [DATA_W-1:0]      prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   serial_link_enable,
   output logic [7:0]             link_mode_select,
   output logic [4:0]             link_test_pattern_select,
   output logic                   chan_a_shutdown,
   output logic                   chan_b_shutdown,
   output logic                   dig_a_shutdown,
   output logic                   dig_b_shutdown,
   output logic                   link_subsys_shutdown,
   output logic                   link_a_run,
   output logic                   link_b_run,
   output logic                   b_samples_undefined,
   output logic [7:0]             lane_clk_a,
   output logic [7:0]             ser_en_a,
   output logic [7:0]             ramp_force_a,
   output logic [7:0]             lane_clk_b,
   output logic [7:0]             ser_en_b,
   output logic [7:0]             ramp_force_b
);
   // ======================================================================
   // State
   typedef struct packed
   {
      cplc_phase_t        phase;
      logic [7:0]         chan_pd;
      logic [7:0]         extra_a;
      logic [7:0]         extra_b;
      logic [7:0]         ctrl;
      logic [7:0]         mode;
      logic [7:0]         test;
      logic [DATA_W-1:0]  prdata;
      logic               pready;
      logic               pslverr;
      logic               conv_a_pd;
      logic               conv_b_pd;
      logic               dig_a_pd;
      logic               dig_b_pd;
      logic               subsys_pd;
      logic               link_a_on;
      logic               link_b_on;
      logic               b_undef;
      logic [7:0]         lclk_a;
      logic [7:0]         ser_a;
      logic [7:0]         ramp_a;
      logic [7:0]         lclk_b;
      logic [7:0]         ser_b;
      logic [7:0]         ramp_b;
   } cplc_state_t;

   localparam cplc_state_t STATE_RESET = '{phase: CPLC_IDLE, chan_pd: REG_RESET, extra_a: REG_RESET,
                                           extra_b: REG_RESET, ctrl: REG_RESET, mode: REG_RESET,
                                           test: REG_RESET, default: '0};

   cplc_state_t         state_reg;
   cplc_state_t         state_next;
   cplc_link_if         lk_a();
   cplc_link_if         lk_b();
   logic                c_conv_a_pd;
   logic                c_conv_b_pd;
   logic                c_dig_a_pd;
   logic                c_dig_b_pd;
   logic                c_subsys_pd;
   logic                c_link_a_on;
   logic                c_link_b_on;
   logic                c_b_undef;
   logic [IDX_W-1:0]    idx;
   logic                hit;
   logic [REG_W-1:0]    rd_byte;
   logic [REG_W-1:0]    status;

   // ======================================================================
   // Power and lane logic
   cplc_chan_pwr u_pwr
   (
      .pd_a      (state_reg.chan_pd[PD_A_BIT]),
      .pd_b      (state_reg.chan_pd[PD_B_BIT]),
      .bind_a    (state_reg.ctrl[CTRL_BIND_A_BIT]),
      .bind_b    (state_reg.ctrl[CTRL_BIND_B_BIT]),
      .link_en   (state_reg.ctrl[CTRL_EN_BIT]),
      .ab_on_a   (state_reg.ctrl[CTRL_AB_ON_A]),
      .conv_a_pd (c_conv_a_pd),
      .conv_b_pd (c_conv_b_pd),
      .dig_a_pd  (c_dig_a_pd),
      .dig_b_pd  (c_dig_b_pd),
      .subsys_pd (c_subsys_pd),
      .link_a_on (c_link_a_on),
      .link_b_on (c_link_b_on),
      .b_undef   (c_b_undef)
   );

   assign lk_a.extra      = state_reg.extra_a;
   assign lk_a.link_on    = c_link_a_on;
   assign lk_a.mode_lanes = mode_lanes_a;
   assign lk_a.test_sel   = state_reg.test[TEST_W-1:0];
   assign lk_b.extra      = state_reg.extra_b;
   assign lk_b.link_on    = c_link_b_on;
   assign lk_b.mode_lanes = mode_lanes_b;
   assign lk_b.test_sel   = state_reg.test[TEST_W-1:0];

   cplc_lane_ctrl u_lane_a
   (
      .lk (lk_a.lane)
   );

   cplc_lane_ctrl u_lane_b
   (
      .lk (lk_b.lane)
   );

   // ======================================================================
   // Register decode
   assign idx    = paddr[ADDR_W-1:IDX_LSB];
   assign status = {2'h0, c_b_undef, c_link_b_on, c_link_a_on, c_subsys_pd, c_conv_b_pd, c_conv_a_pd};

   always_comb
   begin
      hit     = (paddr[IDX_LSB-1:0] == ALIGN_OK);
      rd_byte = REG_RESET;
      unique case (idx)
         IDX_CHAN_PD:   rd_byte = state_reg.chan_pd;
         IDX_EXTRA_A:   rd_byte = state_reg.extra_a;
         IDX_EXTRA_B:   rd_byte = state_reg.extra_b;
         IDX_LINK_CTRL: rd_byte = state_reg.ctrl;
         IDX_LINK_MODE: rd_byte = state_reg.mode;
         IDX_LINK_TEST: rd_byte = state_reg.test;
         IDX_STATUS:    rd_byte = status;
         default:       hit = 1'b0;
      endcase
   end

   // ======================================================================
   // Next state
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg.phase)
         CPLC_IDLE:
         begin
            // Read data sampled in setup so prdata comes from a flop
            if (psel && !penable)
            begin
               state_next.phase   = CPLC_ACCESS;
               state_next.pready  = 1'b1;
               state_next.pslverr = ~hit;
               state_next.prdata  = (hit && !pwrite) ? {24'h000000, rd_byte} : '0;
            end
         end
         CPLC_ACCESS:
         begin
            state_next.phase   = CPLC_IDLE;
            state_next.pready  = 1'b0;
            state_next.pslverr = 1'b0;
            // Writes are accepted even with the link enabled; software owns that ordering
            // relies on software
            if (psel && penable && pwrite && hit && pstrb[0])
            begin
               unique case (idx)
                  IDX_CHAN_PD:   state_next.chan_pd = pwdata[REG_W-1:0];
                  IDX_EXTRA_A:   state_next.extra_a = pwdata[REG_W-1:0];
                  IDX_EXTRA_B:   state_next.extra_b = pwdata[REG_W-1:0];
                  IDX_LINK_CTRL: state_next.ctrl    = pwdata[REG_W-1:0];
                  IDX_LINK_MODE: state_next.mode    = pwdata[REG_W-1:0];
                  IDX_LINK_TEST: state_next.test    = pwdata[REG_W-1:0];
                  default:       state_next.test    = state_reg.test;
               endcase
            end
         end
         default:
         begin
            state_next.phase  = CPLC_IDLE;
            state_next.pready = 1'b0;
         end
      endcase
      state_next.conv_a_pd = c_conv_a_pd;
      state_next.conv_b_pd = c_conv_b_pd;
      state_next.dig_a_pd  = c_dig_a_pd;
      state_next.dig_b_pd  = c_dig_b_pd;
      state_next.subsys_pd = c_subsys_pd;
      state_next.link_a_on = c_link_a_on;
      state_next.link_b_on = c_link_b_on;
      state_next.b_undef   = c_b_undef;
      state_next.lclk_a    = lk_a.lane_clk;
      state_next.ser_a     = lk_a.ser_en;
      state_next.ramp_a    = lk_a.ramp_force;
      state_next.lclk_b    = lk_b.lane_clk;
      state_next.ser_b     = lk_b.ser_en;
      state_next.ramp_b    = lk_b.ramp_force;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         state_reg <= STATE_RESET;
      else
         state_reg <= state_next;
   end

   // ======================================================================
   // Outputs
   assign prdata                   = state_reg.prdata;
   assign pready                   = state_reg.pready;
   assign pslverr                  = state_reg.pslverr;
   assign serial_link_enable       = state_reg.ctrl[CTRL_EN_BIT];
   assign link_mode_select         = state_reg.mode;
   assign link_test_pattern_select = state_reg.test[TEST_W-1:0];
   assign chan_a_shutdown          = state_reg.conv_a_pd;
   assign chan_b_shutdown          = state_reg.conv_b_pd;
   assign dig_a_shutdown           = state_reg.dig_a_pd;
   assign dig_b_shutdown           = state_reg.dig_b_pd;
   assign link_subsys_shutdown     = state_reg.subsys_pd;
   assign link_a_run               = state_reg.link_a_on;
   assign link_b_run               = state_reg.link_b_on;
   assign b_samples_undefined      = state_reg.b_undef;
   assign lane_clk_a               = state_reg.lclk_a;
   assign ser_en_a                 = state_reg.ser_a;
   assign ramp_force_a             = state_reg.ramp_a;
   assign lane_clk_b               = state_reg.lclk_b;
   assign ser_en_b                 = state_reg.ser_b;
   assign ramp_force_b             = state_reg.ramp_b;

   // ======================================================================
   // Assertions
   sequence s_pd_write;
      psel && !penable && pwrite && idx == IDX_CHAN_PD && paddr[IDX_LSB-1:0] == ALIGN_OK && pstrb[0]
      ##1 psel && penable && pready;
   endsequence

   AST_PD_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
      s_pd_write |=> ##1 (chan_b_shutdown == $past(pwdata[PD_B_BIT], 2)))
      else $error("channel B shutdown does not follow written bit");
   AST_CHAN_A: assert property (@(posedge mclk) disable iff (!rstn)
      ##1 chan_a_shutdown == $past(state_reg.chan_pd[PD_A_BIT]))
      else $error("channel A shutdown does not follow register");
   AST_BIND: assert property (@(posedge mclk) disable iff (!rstn)
      $past(state_reg.chan_pd[PD_A_BIT]) && !$past(state_reg.ctrl[CTRL_BIND_A_BIT]) |-> dig_a_shutdown)
      else $error("digital channel A alive with its converter down");
   AST_SUBSYS: assert property (@(posedge mclk) disable iff (!rstn)
      ##1 link_subsys_shutdown == ($past(state_reg.chan_pd[PD_A_BIT]) && $past(state_reg.chan_pd[PD_B_BIT])))
      else $error("subsystem shutdown wrong for channel state");
   AST_LINK_A_KEEP: assert property (@(posedge mclk) disable iff (!rstn)
      b_samples_undefined |-> link_a_run && dig_b_shutdown && !link_subsys_shutdown)
      else $error("link A stopped while only B digital channel is off");
   AST_EXTRA_CLK: assert property (@(posedge mclk) disable iff (!rstn)
      c_link_a_on && state_reg.extra_a[3] |=> lane_clk_a[3])
      else $error("extra lane clock not enabled");
   AST_CLK_ONLY: assert property (@(posedge mclk) disable iff (!rstn)
      !state_reg.extra_a[EXTRA_SER_BIT] && !mode_lanes_a[2] |=> !ser_en_a[2])
      else $error("serializer on with clocks-only selection");
   AST_CHAIN: assert property (@(posedge mclk) disable iff (!rstn)
      ser_en_a[2] |-> &lane_clk_a[2:0])
      else $error("serializer clocked with a lower lane off");
   AST_RAMP: assert property (@(posedge mclk) disable iff (!rstn)
      ramp_force_b[2] |-> lane_clk_b[2] && (link_test_pattern_select == TEST_NORMAL
                                            || link_test_pattern_select == TEST_ALT_RAMP))
      else $error("ramp forced under wrong test selection");
   AST_NO_OVERRIDE: assert property (@(posedge mclk) disable iff (!rstn)
      link_subsys_shutdown |-> lane_clk_a == 8'h00 && lane_clk_b == 8'h00)
      else $error("extra lanes running with subsystem down");
endmodule

// >>> dv/cplc_top_tb.sv
// Purpose: Self-checking bench for cplc_top over APB
// Assumes: Slave answers with no wait states; master waits on pready and counts any wait as a failure
// Notes:   Link enable is cleared around every cfg call; the link mode write after the lanes_gap check in t_extra is made with the link enabled
`timescale 1ns/100ps
module cplc_top_tb
   import cplc_pkg::*;
;
   // ======================================================================
   // Signals
   logic              mclk    = 1'b0;
   logic              rstn    = 1'b0;
   logic              psel    = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite  = 1'b0;
   logic [ADDR_W-1:0] paddr   = '0;
   logic [DATA_W-1:0] pwdata  = '0;
   logic [3:0]        pstrb   = 4'hf;
   logic [7:0]        mode_lanes_a = 8'h01;
   logic [7:0]        mode_lanes_b = 8'h01;
   logic [DATA_W-1:0] prdata;
   logic              pready, pslverr, serial_link_enable;
   logic [7:0]        link_mode_select;
   logic [4:0]        link_test_pattern_select;
   logic              chan_a_shutdown, chan_b_shutdown, dig_a_shutdown, dig_b_shutdown;
   logic              link_subsys_shutdown, link_a_run, link_b_run, b_samples_undefined;
   logic [7:0]        lane_clk_a, ser_en_a, ramp_force_a, lane_clk_b, ser_en_b, ramp_force_b;
   int                n_fail      = 0;
   int                checks_done = 0;

   always #5 mclk = ~mclk;

   cplc_top dut_u
   (
      .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .mode_lanes_a(mode_lanes_a),
      .mode_lanes_b(mode_lanes_b), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_link_enable(serial_link_enable), .link_mode_select(link_mode_select),
      .link_test_pattern_select(link_test_pattern_select), .chan_a_shutdown(chan_a_shutdown),
      .chan_b_shutdown(chan_b_shutdown), .dig_a_shutdown(dig_a_shutdown),
      .dig_b_shutdown(dig_b_shutdown), .link_subsys_shutdown(link_subsys_shutdown),
      .link_a_run(link_a_run), .link_b_run(link_b_run), .b_samples_undefined(b_samples_undefined),
      .lane_clk_a(lane_clk_a), .ser_en_a(ser_en_a), .ramp_force_a(ramp_force_a),
      .lane_clk_b(lane_clk_b), .ser_en_b(ser_en_b), .ramp_force_b(ramp_force_b)
   );

   // ======================================================================
   // Helpers
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Request held until the edge that samples pready high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      @(posedge mclk);
      while (pready !== 1'b1)
      begin
         n++;
         @(posedge mclk);
      end
      chk("pready_wait", 32'h0, n);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] v);
      logic [31:0] q;
      logic        e;
      apb(1'b1, {idx, 2'b00}, {24'h0, v}, q, e);
   endtask

   task automatic rd(input string nm, input logic [9:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      logic        e;
      apb(1'b0, {idx, 2'b00}, 32'h0, q, e);
      chk(nm, {24'h0, exp}, q);
   endtask

   task automatic cfg(input logic [7:0] ctrl, input logic [7:0] pd, input logic [7:0] ea,
                      input logic [7:0] eb, input logic [4:0] tst);
      wr(IDX_LINK_CTRL, ctrl & 8'hfe);
      wr(IDX_CHAN_PD, pd);
      wr(IDX_EXTRA_A, ea);
      wr(IDX_EXTRA_B, eb);
      wr(IDX_LINK_TEST, {3'h0, tst});
      wr(IDX_LINK_CTRL, ctrl);
      repeat (3) @(negedge mclk);
   endtask

   // Order: conv A, conv B, dig A, dig B, subsystem, link A, link B, B undefined
   task automatic chk_pwr(input string nm, input logic [7:0] exp);
      chk(nm, {24'h0, exp}, {24'h0, chan_a_shutdown, chan_b_shutdown, dig_a_shutdown,
          dig_b_shutdown, link_subsys_shutdown, link_a_run, link_b_run, b_samples_undefined});
   endtask

   task automatic chk_ln(input string nm, input logic lb, input logic [23:0] exp);
      chk(nm, {8'h0, exp}, lb ? {8'h0, lane_clk_b, ser_en_b, ramp_force_b}
                              : {8'h0, lane_clk_a, ser_en_a, ramp_force_a});
   endtask

   // ======================================================================
   // Scenarios
   task automatic t_reset;
      logic [31:0] q;
      logic        e;
      chk_pwr("pwr_reset", 8'h00);
      chk_ln("lanes_a_reset", 1'b0, 24'h0);
      rd("pd_reset", IDX_CHAN_PD, REG_RESET);
      rd("ea_reset", IDX_EXTRA_A, REG_RESET);
      rd("eb_reset", IDX_EXTRA_B, REG_RESET);
      pstrb <= 4'h0;
      wr(IDX_CHAN_PD, 8'hff);
      pstrb <= 4'hf;
      rd("pd_nostrb", IDX_CHAN_PD, 8'h00);
      apb(1'b0, 12'h000, 32'h0, q, e);
      chk("err_unmapped", 32'h1, {31'h0, e});
      apb(1'b1, 12'h825, 32'hff, q, e);
      chk("err_misalign", 32'h1, {31'h0, e});
      wr(IDX_CHAN_PD, 8'hfc);
      rd("pd_storage", IDX_CHAN_PD, 8'hfc);
      chk_pwr("pwr_reserved", 8'h00);
      $display("test reset done");
   endtask

   task automatic t_power;
      cfg(8'h01, 8'h02, 8'h00, 8'h00, 5'h00);
      chk_pwr("pwr_b_down", 8'h54);
      chk("link_en", 32'h1, {31'h0, serial_link_enable});
      cfg(8'h05, 8'h01, 8'h00, 8'h00, 5'h00);
      chk_pwr("pwr_a_down_bound", 8'hb0);
      cfg(8'h09, 8'h02, 8'h00, 8'h00, 5'h00);
      chk_pwr("pwr_ab_on_a", 8'h55);
      cfg(8'h01, 8'h03, 8'h07, 8'h07, 5'h00);
      chk_pwr("pwr_both_down", 8'hf8);
      chk_ln("lanes_a_pd", 1'b0, 24'h0);
      rd("status_both", IDX_STATUS, 8'h07);
      $display("test power done");
   endtask

   task automatic t_extra;
      cfg(8'h01, 8'h00, 8'h06, 8'h00, 5'h00);
      chk_ln("lanes_clk_only", 1'b0, 24'h07_01_06);
      @(posedge mclk);
      mode_lanes_a <= 8'h03;
      cfg(8'h01, 8'h00, 8'h04, 8'h00, 5'h00);
      chk_ln("lanes_mode_two", 1'b0, 24'h07_03_04);
      @(posedge mclk);
      mode_lanes_a <= 8'h01;
      cfg(8'h01, 8'h00, 8'h07, 8'h00, 5'h05);
      chk_ln("lanes_ser_on", 1'b0, 24'h07_07_06);
      cfg(8'h01, 8'h00, 8'h0b, 8'h00, 5'h04);
      chk_ln("lanes_gap", 1'b0, 24'h0b_03_00);
      chk("test_sel", 32'h4, {27'h0, link_test_pattern_select});
      wr(IDX_LINK_MODE, 8'h5a);
      repeat (2) @(negedge mclk);
      chk("mode_sel", 32'h5a, {24'h0, link_mode_select});
      cfg(8'h01, 8'h00, 8'h00, 8'h05, 5'h00);
      chk_ln("lanes_b", 1'b1, 24'h05_01_04);
      rd("eb_back", IDX_EXTRA_B, 8'h05);
      cfg(8'h00, 8'h00, 8'h07, 8'h00, 5'h00);
      chk_ln("lanes_link_off", 1'b0, 24'h0);
      chk("link_dis", 32'h0, {31'h0, serial_link_enable});
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      rd("ea_rerst", IDX_EXTRA_A, REG_RESET);
      rd("ctrl_rerst", IDX_LINK_CTRL, REG_RESET);
      $display("test extra lanes done");
   endtask

   // ======================================================================
   // Run control
   task automatic finish_test;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_power();
      t_extra();
      finish_test();
   end

   // Whole run needs a few hundred cycles; reaching 20000 cycles means a hang
   initial
   begin
      #200000;
      n_fail++;
      finish_test();
   end
endmodule
